// *** hdl/fan_ctrl_pkg.sv ***
// constants, tables and carrier types of the fan limit and ramp block
package fan_ctrl_pkg;

	// channel and register counts
	localparam int NUM_CH    = 3;
	localparam int REG_COUNT = 12;

	// register offsets
	localparam logic [7:0] OFF_RAMP_CTRL       = 8'h63;
	localparam logic [7:0] OFF_MIN_DUTY_1      = 8'h64;
	localparam logic [7:0] OFF_MIN_DUTY_2      = 8'h65;
	localparam logic [7:0] OFF_MIN_DUTY_3      = 8'h66;
	localparam logic [7:0] OFF_START_REMOTE_1  = 8'h67;
	localparam logic [7:0] OFF_START_LOCAL     = 8'h68;
	localparam logic [7:0] OFF_START_REMOTE_2  = 8'h69;
	localparam logic [7:0] OFF_CRIT_REMOTE_1   = 8'h6A;
	localparam logic [7:0] OFF_CRIT_LOCAL      = 8'h6B;
	localparam logic [7:0] OFF_CRIT_REMOTE_2   = 8'h6C;
	localparam logic [7:0] OFF_HYST_LOCAL_R1   = 8'h6D;
	localparam logic [7:0] OFF_HYST_REMOTE_2   = 8'h6E;

	// values after reset
	localparam logic [7:0] RST_RAMP_CTRL       = 8'h00;
	localparam logic [7:0] RST_MIN_DUTY        = 8'h80;
	localparam logic [7:0] RST_START_TEMP      = 8'h9A;
	localparam logic [7:0] RST_CRIT_LIMIT      = 8'hA4;
	localparam logic [7:0] RST_CRIT_REMOTE_2_B = 8'hC8;
	localparam logic [7:0] RST_HYST_LOCAL_R1   = 8'h44;
	localparam logic [7:0] RST_HYST_REMOTE_2   = 8'h40;

	// field positions
	localparam int OUT3_RATE_LSB   = 0;
	localparam int OUT3_ENABLE_BIT = 3;
	localparam int OUT2_RATE_LSB   = 4;
	localparam int OUT2_ENABLE_BIT = 7;
	localparam int HYST_LOCAL_LSB  = 0;
	localparam int HYST_R1_LSB     = 4;
	localparam int HYST_R2_LSB     = 4;

	// special codes
	localparam logic [7:0] CRIT_DISABLE_CODE = 8'h80;
	localparam logic [7:0] DUTY_FULL         = 8'hFF;
	localparam logic [7:0] DUTY_OFF          = 8'h00;

	// ramp time slot: 33% to 100% in 35 s at one count per slot
	localparam longint RAMP_FULL_TIME_MS = 35000;
	localparam longint RAMP_FULL_STEPS   = 171;
	localparam longint CLOCK_MHZ         = 200;
	localparam int     RAMP_SLOT_CYCLES  =
		int'(RAMP_FULL_TIME_MS * 1000 * CLOCK_MHZ / RAMP_FULL_STEPS);

	// duty increment per slot, indexed by the 3-bit rate code
	localparam logic [7:0][7:0] RAMP_STEPS = {8'h30, 8'h18, 8'h0C, 8'h08,
		8'h04, 8'h03, 8'h02, 8'h01};

	// 65536 / span in degrees, indexed by the 4-bit slope code
	localparam logic [15:0][15:0] SLOPE_GAIN = {16'h0333, 16'h04CD,
		16'h0666, 16'h0800, 16'h099A, 16'h0CCD, 16'h1000, 16'h1333,
		16'h199A, 16'h2000, 16'h2666, 16'h3333, 16'h4000, 16'h4CCD,
		16'h6666, 16'h8000};

	// register access request
	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// whole state of the block
	typedef struct packed {
		logic [REG_COUNT-1:0][7:0] regs;
		logic [NUM_CH-1:0]         running;
		logic [NUM_CH-1:0]         crit;
		logic [NUM_CH-1:0][7:0]    applied;
		logic [31:0]               slot_cnt;
		logic [7:0]                rdata;
		logic                      override;
		logic                      pin_oe;
		logic                      pin_out;
		logic [1:0]                pin_sync;
		logic                      pin_level;
	} state_t;

endpackage

// *** hdl/fan_drive_limit_and_ramp_control.sv ***
// fan drive limit, hysteresis, fail-safe and ramp control with its registers
`timescale 1ns/1ps

// Overview of operation
// - output 3 ramps gradually toward each new target duty
// - rate codes 0..7 give steps 1,2,3,4,8,12,24,48 per slot
// - output 3 ramping only while ramp control bit 3 is one
// - output 2 ramps the same way, rate code in bits 6 to 4
// - output 2 ramping only while ramp control bit 7 is one
// - three 8-bit minimum duty registers, linear 0x00 off to 0xFF full
// - lock set makes every register here ignore writes
// - above start temperature fan runs minimum duty, rising with slope
// - any channel above its critical limit forces all outputs full
// - critical limit 0x80 disables that channel's fail-safe
// - fail-safe holds until temperature below limit minus hysteresis
// - overtemp pin as output drives low when limit exceeded by 0.25
// - hysteresis register: local bits 3..0, remote 1 bits 7..4
// - remote 2 hysteresis bits 7..4, resets 0x40; first resets 0x44
// - limits reset 0xA4; remote 2 limit 0xA4 or 0xC8 by variant
// - below start, fan keeps minimum until start minus hysteresis
// - hold bit picks 0% or minimum below start minus hysteresis
module fan_drive_limit_and_ramp_control
	import fan_ctrl_pkg::*;
#(
	parameter int unsigned SLOT_CYCLES     = RAMP_SLOT_CYCLES,
	parameter bit          VARIANT_B       = 1'b0
)
(
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     reset,
	// register access from the management bus front end
	input  wire reg_req_t                 reg_req,
	output logic [7:0]                    reg_rdata,
	// configuration from outside this block
	input  wire logic                     config_lock,
	input  wire logic [NUM_CH-1:0]        below_start_hold,
	input  wire logic [NUM_CH-1:0][3:0]   temp_slope_span,
	input  wire logic                     overtemp_pin_is_output,
	// measured temperatures, integer in [9:2], quarter degrees in [1:0]
	input  wire logic [NUM_CH-1:0][9:0]   temps,
	// fan drive duty values
	output logic [NUM_CH-1:0][7:0]        fan_drive,
	output logic                          override_active,
	// overtemperature pin, open drain
	input  wire logic                     overtemp_pin_in,
	output logic                          overtemp_pin_out,
	output logic                          overtemp_pin_oe,
	output logic                          overtemp_pin_level
);

	// refuse a slot length the counter cannot serve
	if (SLOT_CYCLES < 1)
	begin : g_slot_check
		$error("SLOT_CYCLES must be at least one");
	end

	// the register file is indexed by offset from the first register
	if (REG_COUNT != int'(OFF_HYST_REMOTE_2) - int'(OFF_RAMP_CTRL) + 1)
	begin : g_map_check
		$error("register count does not match the offset span");
	end

	// hysteresis and ramp fields are laid out for exactly three outputs
	if (NUM_CH != 3)
	begin : g_chan_check
		$error("only three channels are served");
	end

	// address decode shared by read and write
	function automatic logic reg_hit(input logic [7:0] addr);
		reg_hit = (addr >= OFF_RAMP_CTRL) && (addr <= OFF_HYST_REMOTE_2);
	endfunction

	function automatic logic [3:0] reg_index(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - OFF_RAMP_CTRL;
		reg_index = diff[3:0];
	endfunction

	// hysteresis of one channel: remote 1, local, remote 2
	function automatic logic [3:0] hyst_of(
		input logic [REG_COUNT-1:0][7:0] regs,
		input int                        ch);
		logic [7:0] h1;
		logic [7:0] h2;
		h1 = regs[reg_index(OFF_HYST_LOCAL_R1)];
		h2 = regs[reg_index(OFF_HYST_REMOTE_2)];
		if (ch == 0)
			hyst_of = h1[HYST_R1_LSB +: 4];
		else if (ch == 1)
			hyst_of = h1[HYST_LOCAL_LSB +: 4];
		else
			hyst_of = h2[HYST_R2_LSB +: 4];
	endfunction

	// value minus hysteresis, floored at zero so a low limit cannot wrap
	function automatic logic [7:0] minus_hyst(
		input logic [7:0] value,
		input logic [3:0] hyst);
		if (value > {4'h0, hyst})
			minus_hyst = value - {4'h0, hyst};
		else
			minus_hyst = 8'h00;
	endfunction

	// reset image of the register file
	function automatic logic [REG_COUNT-1:0][7:0] reset_regs();
		logic [REG_COUNT-1:0][7:0] r;
		r = '0;
		r[reg_index(OFF_RAMP_CTRL)]      = RST_RAMP_CTRL;
		r[reg_index(OFF_MIN_DUTY_1)]     = RST_MIN_DUTY;
		r[reg_index(OFF_MIN_DUTY_2)]     = RST_MIN_DUTY;
		r[reg_index(OFF_MIN_DUTY_3)]     = RST_MIN_DUTY;
		r[reg_index(OFF_START_REMOTE_1)] = RST_START_TEMP;
		r[reg_index(OFF_START_LOCAL)]    = RST_START_TEMP;
		r[reg_index(OFF_START_REMOTE_2)] = RST_START_TEMP;
		r[reg_index(OFF_CRIT_REMOTE_1)]  = RST_CRIT_LIMIT;
		r[reg_index(OFF_CRIT_LOCAL)]     = RST_CRIT_LIMIT;
		r[reg_index(OFF_CRIT_REMOTE_2)]  = VARIANT_B ?
			RST_CRIT_REMOTE_2_B : RST_CRIT_LIMIT;
		r[reg_index(OFF_HYST_LOCAL_R1)]  = RST_HYST_LOCAL_R1;
		r[reg_index(OFF_HYST_REMOTE_2)]  = RST_HYST_REMOTE_2;
		reset_regs = r;
	endfunction

	// duty from temperature above start along the selected slope
	function automatic logic [7:0] slope_duty(
		input logic [7:0] floor_duty,
		input logic [7:0] delta,
		input logic [3:0] span);
		logic [31:0] prod;
		logic [8:0]  sum;
		prod = 32'(DUTY_FULL - floor_duty) * 32'(delta)
			* 32'(SLOPE_GAIN[span]);
		sum = {1'b0, floor_duty} + {1'b0, prod[23:16]};
		if ((prod[31:24] != 8'h00) || sum[8])
			slope_duty = DUTY_FULL;
		else
			slope_duty = sum[7:0];
	endfunction

	// one ramp move toward target, never past it
	function automatic logic [7:0] ramp_move(
		input logic [7:0] now,
		input logic [7:0] target,
		input logic [7:0] step);
		if (target > now)
		begin
			if ((target - now) > step)
				ramp_move = now + step;
			else
				ramp_move = target;
		end
		else if (now > target)
		begin
			if ((now - target) > step)
				ramp_move = now - step;
			else
				ramp_move = target;
		end
		else
			ramp_move = now;
	endfunction

	state_t st_reg;
	state_t st_next;

	// reset image: registers at defaults, pin released and seen idle high,
	// so the synchronised level shows no false low right after reset
	localparam state_t ST_AT_RESET = '{
		regs:      reset_regs(),
		pin_out:   1'b1,
		pin_sync:  2'b11,
		pin_level: 1'b1,
		default:   '0
	};

	// next state of the whole block
	always_comb
	begin
		logic [7:0]  t;
		logic [7:0]  start;
		logic [7:0]  limit;
		logic [3:0]  hyst;
		logic [7:0]  target;
		logic [7:0]  floor_duty;
		logic [7:0]  ctrl;
		logic        ramp_en;
		logic [2:0]  rate;
		logic        tick;
		logic        any_crit;
		logic        any_pin;
		t          = 8'h00;
		start      = 8'h00;
		limit      = 8'h00;
		hyst       = 4'h0;
		target     = 8'h00;
		floor_duty = 8'h00;
		ctrl       = st_reg.regs[reg_index(OFF_RAMP_CTRL)];
		ramp_en    = 1'b0;
		rate       = 3'b000;
		any_pin    = 1'b0;
		tick       = 1'b0;
		any_crit   = 1'b0;
		st_next    = st_reg;

		// pin synchroniser; first stage feeds only the second
		st_next.pin_sync  = {st_reg.pin_sync[0], overtemp_pin_in};
		st_next.pin_level = st_reg.pin_sync[1];

		// register read, unmapped addresses answer zero
		if (reg_req.read)
		begin
			if (reg_hit(reg_req.addr))
				st_next.rdata = st_reg.regs[reg_index(reg_req.addr)];
			else
				st_next.rdata = 8'h00;
		end

		if (reg_req.write && !config_lock && reg_hit(reg_req.addr))
			st_next.regs[reg_index(reg_req.addr)] = reg_req.wdata;

		// free running slot timer for the ramp
		tick = (st_reg.slot_cnt == 32'(SLOT_CYCLES - 1));
		if (tick)
			st_next.slot_cnt = 32'h00000000;
		else
			st_next.slot_cnt = st_reg.slot_cnt + 32'h00000001;

		// per channel hysteresis state; fan k follows channel k
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			// integer degrees in the register code
			t     = temps[ch][9:2];
			start = st_reg.regs[reg_index(OFF_START_REMOTE_1) + 4'(ch)];
			limit = st_reg.regs[reg_index(OFF_CRIT_REMOTE_1) + 4'(ch)];
			hyst  = hyst_of(st_reg.regs, ch);

			if (t > start)
				st_next.running[ch] = 1'b1;
			else if (t <= minus_hyst(start, hyst))
				st_next.running[ch] = 1'b0;

			if (limit == CRIT_DISABLE_CODE)
				st_next.crit[ch] = 1'b0;
			else if (t > limit)
				st_next.crit[ch] = 1'b1;
			else if (t < minus_hyst(limit, hyst))
				st_next.crit[ch] = 1'b0;

			if (temps[ch] > {limit, 2'b00})
				any_pin = 1'b1;
		end
		any_crit = |st_next.crit;

		// per output target duty and ramp
		for (int k = 0; k < NUM_CH; k++)
		begin
			t     = temps[k][9:2];
			start = st_reg.regs[reg_index(OFF_START_REMOTE_1) + 4'(k)];
			floor_duty = st_reg.regs[reg_index(OFF_MIN_DUTY_1) + 4'(k)];

			if (t > start)
				target = slope_duty(floor_duty, t - start,
					temp_slope_span[k]);
			else if (st_next.running[k])
				target = floor_duty;
			// hold bit selects off or minimum
			else if (below_start_hold[k])
				target = floor_duty;
			else
				target = DUTY_OFF;

			// output 1 ramp lives outside this block
			if (k == 1)
			begin
				ramp_en = ctrl[OUT2_ENABLE_BIT];
				rate    = ctrl[OUT2_RATE_LSB +: 3];
			end
			else if (k == 2)
			begin
				ramp_en = ctrl[OUT3_ENABLE_BIT];
				rate    = ctrl[OUT3_RATE_LSB +: 3];
			end
			else
			begin
				ramp_en = 1'b0;
				rate    = 3'b000;
			end

			// fail-safe jumps at once; ramping would delay cooling
			if (any_crit)
				st_next.applied[k] = DUTY_FULL;
			else if (!ramp_en)
				st_next.applied[k] = target;
			// one step per slot, clamped at target
			else if (tick)
				st_next.applied[k] = ramp_move(st_reg.applied[k],
					target, RAMP_STEPS[rate]);
		end

		// override flag and open drain pin
		st_next.override = any_crit;
		st_next.pin_oe   = overtemp_pin_is_output && any_pin;
		st_next.pin_out  = !(overtemp_pin_is_output && any_pin);
	end

	// state register
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			st_reg <= ST_AT_RESET;
		end
		else
			st_reg <= st_next;
	end

	// outputs straight from the state register
	assign reg_rdata          = st_reg.rdata;
	assign fan_drive          = st_reg.applied;
	assign override_active    = st_reg.override;
	assign overtemp_pin_out   = st_reg.pin_out;
	assign overtemp_pin_oe    = st_reg.pin_oe;
	assign overtemp_pin_level = st_reg.pin_level;

endmodule

// *** hdl/empty_note_unused.sv ***
// no logic here: the whole block lives in one design file

// *** verif/fan_ctrl_chk.sv ***
// port assertions for the fan limit and ramp block
`timescale 1ns/1ps
module fan_ctrl_chk
	import fan_ctrl_pkg::*;
(
	// clock and reset
	input wire logic                   clock,
	input wire logic                   reset,
	// register side
	input wire reg_req_t               reg_req,
	input wire logic [7:0]             reg_rdata,
	// fan side
	input wire logic [NUM_CH-1:0]      below_start_hold,
	input wire logic                   overtemp_pin_is_output,
	input wire logic [NUM_CH-1:0][9:0] temps,
	input wire logic [NUM_CH-1:0][7:0] fan_drive,
	input wire logic                   override_active,
	input wire logic                   overtemp_pin_in,
	input wire logic                   overtemp_pin_out,
	input wire logic                   overtemp_pin_oe,
	input wire logic                   overtemp_pin_level
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// register answers
	rd_unmapped_a: assert property (reg_req.read && (reg_req.addr < 8'h63
		|| reg_req.addr > 8'h6E) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_req.read |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	// fail-safe drives all outputs full, and its release needs a cause
	full_on_override_a: assert property (
		override_active |-> fan_drive == {NUM_CH{DUTY_FULL}})
		else $error("override without full drive");
	override_release_a: assert property ($fell(override_active) |->
		$past(temps) != $past(temps, 2) || $past(reg_req.write, 2))
		else $error("override dropped without cause");
	// pin driving is open drain, only when configured
	pin_polarity_a: assert property (
		overtemp_pin_out == !overtemp_pin_oe)
		else $error("pin out and enable disagree");
	pin_config_a: assert property (
		$rose(overtemp_pin_oe) |-> $past(overtemp_pin_is_output))
		else $error("pin driven while input");
	pin_sync_a: assert property ($stable(overtemp_pin_in)[*4]
		|=> overtemp_pin_level == $past(overtemp_pin_in))
		else $error("pin level not synced");
	// cold channel with hold clear goes off
	cold_off_a: assert property (
		(temps == '0 && !below_start_hold[0])[*2] |=> fan_drive[0] == 8'h00)
		else $error("cold output not off");

	// main scenarios reached
	cover property ($rose(override_active));
	cover property ($rose(overtemp_pin_oe));
	cover property (!override_active && $changed(fan_drive[1]));
endmodule

bind fan_drive_limit_and_ramp_control fan_ctrl_chk i_chk (.clock, .reset,
	.reg_req, .reg_rdata, .below_start_hold, .overtemp_pin_is_output,
	.temps, .fan_drive, .override_active, .overtemp_pin_in,
	.overtemp_pin_out, .overtemp_pin_oe, .overtemp_pin_level);

// *** verif/mgmt_host.sv ***
// management host model issuing register cycles
`timescale 1ns/1ps
module mgmt_host
	import fan_ctrl_pkg::*;
(
	// clock
	input  wire logic       clock,
	// request out, answer in
	output reg_req_t        reg_req,
	input  wire logic [7:0] reg_rdata
);
	// idle bus from time zero
	initial reg_req = '0;

	// write: strobe held until the edge that takes it
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		reg_req.write <= 1'b0;
	endtask

	// read: data registered, so taken one edge after the strobe
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		reg_req.read <= 1'b0;
		@(posedge clock);
		d = reg_rdata;
	endtask
endmodule

// *** verif/tb.sv ***
// self-checking bench for the fan limit and ramp block
`timescale 1ns/1ps
module tb;
	import fan_ctrl_pkg::*;
	logic                   clock = 1'b0;
	logic                   reset = 1'b1;
	reg_req_t               reg_req;
	logic [7:0]             reg_rdata;
	logic                   config_lock = 1'b0;
	logic [NUM_CH-1:0]      below_start_hold = '0;
	logic [NUM_CH-1:0][3:0] temp_slope_span = '1;
	logic                   pin_is_output = 1'b1;
	logic [NUM_CH-1:0][9:0] temps = '0;
	logic [NUM_CH-1:0][7:0] fan_drive;
	logic                   override_active, pin_in, pin_out, pin_oe;
	logic                   pin_level, ext_pin = 1'b1;
	int                     miscompares = 0, n_checks = 0, cycles = 0;
	logic [7:0]             rst_tab [12] = '{8'h00, 8'h80, 8'h80, 8'h80,
		8'h9A, 8'h9A, 8'h9A, 8'hA4, 8'hA4, 8'hA4, 8'h44, 8'h40};
	logic [7:0]             step_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h04,
		8'h08, 8'h0C, 8'h18, 8'h30};
	logic [7:0]             rdata_b;
	localparam int          SLOT = 8;

	fan_drive_limit_and_ramp_control #(.SLOT_CYCLES(SLOT), .VARIANT_B(1'b0))
	i_dut (.clock, .reset, .reg_req, .reg_rdata, .config_lock,
		.below_start_hold, .temp_slope_span,
		.overtemp_pin_is_output(pin_is_output), .temps, .fan_drive,
		.override_active, .overtemp_pin_in(pin_in),
		.overtemp_pin_out(pin_out), .overtemp_pin_oe(pin_oe),
		.overtemp_pin_level(pin_level));
	mgmt_host i_host (.clock, .reg_req, .reg_rdata);

	// second copy with the other limit default; only its read data is used
	fan_drive_limit_and_ramp_control #(.SLOT_CYCLES(SLOT), .VARIANT_B(1'b1))
	i_dut_b (.clock, .reset, .reg_req, .reg_rdata(rdata_b), .config_lock,
		.below_start_hold, .temp_slope_span,
		.overtemp_pin_is_output(pin_is_output), .temps, .fan_drive(),
		.override_active(), .overtemp_pin_in(1'b1),
		.overtemp_pin_out(), .overtemp_pin_oe(), .overtemp_pin_level());

	// open-drain wire: low when either side pulls it
	assign pin_in = ext_pin & ~pin_oe;

	// 200 MHz clock
	initial
	begin
		forever #2.5 clock = ~clock;
	end

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		i_host.read_reg(a, d);
		check($sformatf("reg %h", a), d, exp);
	endtask

	task automatic set_temp(input int ch, input logic [7:0] t, input int n);
		@(posedge clock);
		temps[ch] <= {t, 2'b00};
		repeat (n) @(posedge clock);
	endtask

	// cold start, then step toward full; a step is clamped at the top
	task automatic ramp_run(input int ch, input logic [7:0] ctrl,
		input logic [7:0] step);
		logic [7:0] prev;
		int         gap;
		i_host.write_reg(OFF_RAMP_CTRL, 8'h00);
		set_temp(ch, 8'h00, 3);
		i_host.write_reg(OFF_RAMP_CTRL, ctrl);
		prev = fan_drive[ch];
		gap  = 0;
		set_temp(ch, 8'h9B, 0);
		for (int i = 0; i < 2200 && prev !== 8'hFF; i++)
		begin
			@(posedge clock);
			gap++;
			if (fan_drive[ch] !== prev)
			begin
				if (prev !== 8'h00)
					check("ramp slot", 8'(gap), 8'(SLOT));
				check("ramp step", fan_drive[ch],
					(8'hFF - prev < step) ? 8'hFF : prev + step);
				prev = fan_drive[ch];
				gap  = 0;
			end
		end
		check("ramp end", fan_drive[ch], 8'hFF);
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// hang guard, well above the longest ramp sequence
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			miscompares++;
			finish_test();
		end
	end

	// test sequence
	initial
	begin
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		for (int i = 0; i < 12; i++)
			rd_chk(8'h63 + 8'(i), rst_tab[i]);
		rd_chk(OFF_CRIT_REMOTE_2, 8'hA4);
		check("variant limit", rdata_b, 8'hC8);
		i_host.write_reg(OFF_MIN_DUTY_1, 8'h40);
		rd_chk(OFF_MIN_DUTY_1, 8'h40);
		@(posedge clock) config_lock <= 1'b1;
		i_host.write_reg(OFF_MIN_DUTY_1, 8'h11);
		rd_chk(OFF_MIN_DUTY_1, 8'h40);
		@(posedge clock) config_lock <= 1'b0;
		rd_chk(8'h70, 8'h00);
		$display("registers done");

		set_temp(0, 8'h00, 3);
		check("cold off", fan_drive[0], 8'h00);
		@(posedge clock) below_start_hold <= 3'b001;
		set_temp(0, 8'h00, 3);
		check("cold hold", fan_drive[0], 8'h40);
		@(posedge clock) below_start_hold <= 3'b000;
		set_temp(0, 8'h9B, 3);
		check("above start", fan_drive[0],
			8'h40 + 8'((32'h000000BF * 32'h00000333) >> 16));
		@(posedge clock) temp_slope_span[0] <= 4'h0;
		set_temp(0, 8'h9B, 3);
		check("steep slope", fan_drive[0],
			8'h40 + 8'((32'h000000BF * 32'h00008000) >> 16));
		@(posedge clock) temp_slope_span[0] <= 4'hF;
		set_temp(0, 8'h98, 3);
		check("inside hyst", fan_drive[0], 8'h40);
		set_temp(0, 8'h96, 3);
		check("below hyst", fan_drive[0], 8'h00);
		$display("start temp done");

		set_temp(1, 8'hA5, 3);
		for (int k = 0; k < NUM_CH; k++)
			check("full", fan_drive[k], 8'hFF);
		check("pin oe", {7'h0, pin_oe}, 8'h01);
		set_temp(1, 8'hA0, 3);
		check("held", {7'h0, override_active}, 8'h01);
		set_temp(1, 8'h9F, 3);
		check("released", {7'h0, override_active}, 8'h00);
		i_host.write_reg(OFF_CRIT_LOCAL, 8'h80);
		set_temp(1, 8'hC0, 3);
		check("disabled", {7'h0, override_active}, 8'h00);
		@(posedge clock) pin_is_output <= 1'b0;
		set_temp(1, 8'hC0, 3);
		check("pin input", {7'h0, pin_oe}, 8'h00);
		@(posedge clock) ext_pin <= 1'b0;
		set_temp(1, 8'h00, 5);
		check("pin level", {7'h0, pin_level}, 8'h00);
		@(posedge clock) ext_pin <= 1'b1;
		i_host.write_reg(OFF_CRIT_LOCAL, 8'hA4);
		$display("fail-safe done");

		i_host.write_reg(OFF_MIN_DUTY_2, 8'hFF);
		i_host.write_reg(OFF_MIN_DUTY_3, 8'hFF);
		for (int k = 0; k < 8; k++)
			ramp_run(1, {1'b1, 3'(k), 4'h0}, step_tab[k]);
		ramp_run(2, 8'h0C, 8'h08);
		ramp_run(2, 8'h80, 8'hFF);
		ramp_run(1, 8'h0F, 8'hFF);
		$display("ramp done");
		finish_test();
	end
endmodule
